/* File: mgmt_serial_slave.sv */
// management serial port frame engine: preamble, header, turnaround, 16 data bits
// assumes mdc and mdio_in are synchronous to clk and mdc runs well below clk/2
`default_nettype none

module mgmt_serial_slave
  import phy_cfg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // gating and address
  input wire logic enable,
  input wire logic [4:0] phy_addr,
  // serial pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // register side
  output mgmt_req_t req,
  input wire logic [15:0] rd_data
);

  logic mdc_prev_reg, mdc_prev_next;
  mdio_state_t st_reg, st_next;
  logic [5:0] ones_reg, ones_next;
  logic [4:0] bits_reg, bits_next;
  logic [15:0] shift_reg, shift_next;
  logic [12:0] hdr_reg, hdr_next;
  logic oe_reg, oe_next;
  logic out_reg, out_next;
  logic wr_reg, wr_next;
  logic rise;

  assign rise = mdc & ~mdc_prev_reg;
  assign mdio_out = out_reg;
  assign mdio_oe = oe_reg & enable; // released at once when gated off
  assign req = '{wr: wr_reg, addr: hdr_reg[4:0], data: shift_reg};

  // frame sequencing on each mdc rising edge
  always_comb begin
    mdc_prev_next = mdc;
    st_next = st_reg;
    ones_next = ones_reg;
    bits_next = bits_reg;
    shift_next = shift_reg;
    hdr_next = hdr_reg;
    oe_next = oe_reg;
    out_next = out_reg;
    wr_next = 1'b0;
    if (!enable) begin
      st_next = MD_PREAMBLE;
      ones_next = 6'h00;
      oe_next = 1'b0;
    end else if (rise) begin
      unique case (st_reg)
        MD_PREAMBLE: begin
          if (mdio_in) begin
            ones_next = (ones_reg == PREAMBLE_BITS) ? ones_reg : ones_reg + 6'h01;
          end else begin
            if (ones_reg == PREAMBLE_BITS) begin
              st_next = MD_HEADER;
              bits_next = 5'h00;
            end
            ones_next = 6'h00;
          end
        end
        MD_HEADER: begin
          hdr_next = {hdr_reg[11:0], mdio_in};
          bits_next = bits_reg + 5'h01;
          if (bits_reg == HDR_LAST) begin
            st_next = MD_PREAMBLE;
            bits_next = 5'h00;
            // frames for another address are simply skipped
            if (hdr_next[12] && hdr_next[9:5] == phy_addr) begin
              if (hdr_next[11:10] == 2'b10) begin
                st_next = MD_TA_READ;
              end else if (hdr_next[11:10] == 2'b01) begin
                st_next = MD_TA_WRITE;
              end
            end
          end
        end
        MD_TA_READ: begin
          shift_next = rd_data;
          oe_next = 1'b1;
          out_next = 1'b0;
          st_next = MD_READ;
          bits_next = 5'h00;
        end
        MD_READ: begin
          if (bits_reg == DATA_BITS) begin
            oe_next = 1'b0;
            st_next = MD_PREAMBLE;
          end else begin
            out_next = shift_reg[15];
            shift_next = {shift_reg[14:0], 1'b0};
            bits_next = bits_reg + 5'h01;
          end
        end
        MD_TA_WRITE: begin
          bits_next = bits_reg + 5'h01;
          if (bits_reg == 5'h01) begin
            st_next = MD_WRITE;
            bits_next = 5'h00;
          end
        end
        MD_WRITE: begin
          shift_next = {shift_reg[14:0], mdio_in};
          bits_next = bits_reg + 5'h01;
          if (bits_reg == DATA_BITS - 5'h01) begin
            wr_next = 1'b1;
            st_next = MD_PREAMBLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mdc_prev_reg <= 1'b0;
      st_reg <= MD_PREAMBLE;
      ones_reg <= 6'h00;
      bits_reg <= 5'h00;
      shift_reg <= 16'h0000;
      hdr_reg <= 13'h0000;
      oe_reg <= 1'b0;
      out_reg <= 1'b0;
      wr_reg <= 1'b0;
    end else begin
      mdc_prev_reg <= mdc_prev_next;
      st_reg <= st_next;
      ones_reg <= ones_next;
      bits_reg <= bits_next;
      shift_reg <= shift_next;
      hdr_reg <= hdr_next;
      oe_reg <= oe_next;
      out_reg <= out_next;
      wr_reg <= wr_next;
    end
  end

endmodule : mgmt_serial_slave

`default_nettype wire

/* File: mgmt_station.sv */
// management station model: clause 22 frames on mdc and mdio
// assumes mdc half period of four clk periods and a pull-up on the shared data line
`default_nettype none

module mgmt_station (
  // clock
  input wire logic clk,
  // serial pins
  output logic mdc,
  output logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv = 1'b1;
  logic drv_en = 1'b0;

  // resolved line: pull-up wins when nobody drives
  assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv : 1'b1);

  // mdc stands low between frames
  initial mdc = 1'b0;

  // one bit: set data with mdc low, raise, sample in the high phase
  task automatic bit_cyc(input logic b, input logic en, output logic seen);
    drv = b;
    drv_en = en;
    repeat (4) @(posedge clk);
    #5 mdc = 1'b1;
    repeat (4) @(posedge clk);
    #5 seen = mdio_in;
    mdc = 1'b0;
  endtask : bit_cyc

  // whole frame; reads take one turnaround bit since the device drives the second
  task automatic frame(input logic wr, input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [13:0] hdr;
    logic s;
    hdr = {2'b01, wr ? 2'b01 : 2'b10, pa, ra};
    for (int i = 0; i < 32; i++) bit_cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cyc(hdr[i], 1'b1, s);
    bit_cyc(1'b1, wr, s);
    if (wr) bit_cyc(1'b0, 1'b1, s);
    for (int i = 15; i >= 0; i--) bit_cyc(wd[i], wr, rd[i]);
    bit_cyc(1'b1, 1'b0, s);
    drv_en = 1'b0;
  endtask : frame
endmodule : mgmt_station

`default_nettype wire

/* File: phy_cfg_pkg.sv */
// constants, types and strap decoders for the transceiver config, reset and power block
// assumes one 20 MHz clock; register numbers are those seen on the management serial port
// Functional notes
// R01: managed mode: pins give register defaults, then only management writes change bits.
// R02: strap mode ignores management writes to configuration registers.
// R03: power-up and every hardware reset sample straps into register bits.
// R04: forced mode runs at once; autoneg mode starts negotiation with parallel detection.
// R05: six selections: fiber, 100 full/half, 10 full/half, autoneg.
// R06: hardware power-down stops port and clock, tristates outputs, drops pulls.
// R07: no management access answered during hardware power-down.
// R08: software power-down bit stops the port; registers stay accessible.
// R09: sleep pin enables sleep; in managed mode a config bit overrides it.
// R10: sleep after no line energy for interval set by two-bit field.
// R11: management transactions still answered while asleep.
// R12: energy wakes device to search link; no link within interval, sleep again.
// R13: never sleep in fiber mode.
// R14: writing one to control reset bit starts a software reset.
// R15: software reset restores advertisement from straps latched at hardware reset.
// R16: registers readable during software reset; reset bit reads zero when done.
// R17: registers unavailable for 1 ms after hardware reset release.
// R18: strap one low: autoneg off, strap two gives speed, three gives duplex.
// R19: strap one high: autoneg on, speed set, duplex and advertisement per table.
// R20: disable pin high selects strap mode with management port off.
// R21: registers are 16 bits, numbered 0 to 31.
// R22: reset bit clears itself when the software reset ends.
// R23: straps held in flops at reset release; later pin changes ignored.
`default_nettype none

package phy_cfg_pkg;

  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int RECOVERY_MS = 1;
  localparam logic [3:0] SWRST_CYCLES = 4'h6;
  localparam logic [11:0] SLEEP_MS_SHORT = 12'd1040;
  localparam logic [11:0] SLEEP_MS_MID = 12'd2040;
  localparam logic [11:0] SLEEP_MS_LONG = 12'd3040;

  // serial frame shape
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [4:0] HDR_LAST = 5'hc;
  localparam logic [4:0] DATA_BITS = 5'h10;

  // register numbers
  localparam logic [4:0] REG_BASIC_CONTROL = 5'h00;
  localparam logic [4:0] REG_AUTONEG_ADVERTISE = 5'h04;
  localparam logic [4:0] REG_VENDOR_CONFIGURATION = 5'h10;

  // basic_control fields
  localparam int CTRL_RESET = 15;
  localparam int CTRL_SPEED = 13;
  localparam int CTRL_AN_EN = 12;
  localparam int CTRL_PWRDN = 11;
  localparam int CTRL_AN_RESTART = 9;
  localparam int CTRL_DUPLEX = 8;
  localparam logic [15:0] CTRL_WMASK = 16'h3900;

  // autoneg_advertise fields
  localparam int ADV_100_FULL = 8;
  localparam int ADV_100_HALF = 7;
  localparam int ADV_10_FULL = 6;
  localparam int ADV_10_HALF = 5;
  localparam logic [15:0] ADV_WMASK = 16'h01e0;
  localparam logic [15:0] ADV_SELECTOR = 16'h0001;

  // vendor_configuration fields
  localparam int CFG_SLEEP_EN = 6;
  localparam int CFG_SLEEP_TIME = 3;
  localparam int CFG_FIBER = 0;
  localparam logic [15:0] CFG_WMASK = 16'h0059;
  localparam logic [15:0] CFG_RESET = 16'h0010;

  typedef struct packed {
    logic an;
    logic speed;
    logic duplex;
    logic sleep;
    logic fiber;
  } strap_t;

  typedef struct packed {
    logic wr;
    logic [4:0] addr;
    logic [15:0] data;
  } mgmt_req_t;

  typedef enum logic [2:0] {MODE_FX, MODE_TX_FULL, MODE_TX_HALF, MODE_T_FULL, MODE_T_HALF, MODE_AUTONEG} link_mode_t;
  typedef enum logic [1:0] {SLP_AWAKE, SLP_ASLEEP, SLP_SEARCH} sleep_state_t;
  typedef enum logic [2:0] {MD_PREAMBLE, MD_HEADER, MD_TA_READ, MD_READ, MD_TA_WRITE, MD_WRITE} mdio_state_t;

  // control bits from straps
  function automatic logic [15:0] strap_control(input strap_t s);
    logic [15:0] c;
    c = 16'h0000;
    c[CTRL_AN_EN] = s.an; // see R18
    c[CTRL_SPEED] = s.an | s.speed; // see R19
    c[CTRL_DUPLEX] = s.duplex;
    return c;
  endfunction : strap_control

  // advertisement bits from straps; all abilities when autoneg is strapped off
  function automatic logic [15:0] strap_advert(input strap_t s);
    logic [15:0] a;
    a = ADV_SELECTOR;
    a[ADV_100_FULL] = s.duplex | ~s.an; // see R19
    a[ADV_100_HALF] = 1'b1;
    a[ADV_10_FULL] = (s.speed & s.duplex) | ~s.an;
    a[ADV_10_HALF] = s.speed | ~s.an;
    return a;
  endfunction : strap_advert

  function automatic logic [15:0] strap_config(input strap_t s);
    logic [15:0] f;
    f = CFG_RESET;
    f[CFG_SLEEP_EN] = s.sleep;
    f[CFG_FIBER] = s.fiber;
    return f;
  endfunction : strap_config

endpackage : phy_cfg_pkg

`default_nettype wire

/* File: phy_config_reset_power.sv */
// strap loading, reset sequencing, register file and reduced-power control
// assumes all pins synchronous to clk; rst_b is the hardware reset, low active
`default_nettype none

module phy_config_reset_power
  import phy_cfg_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // straps and mode pins
  input wire logic [2:0] indicator_strap_pins,
  input wire logic sleep_pin,
  input wire logic fiber_pin,
  input wire logic mgmt_port_disable_pin,
  input wire logic hw_powerdown_pin,
  input wire logic [4:0] phy_addr,
  // management serial port
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // line status
  input wire logic energy_detect,
  input wire logic link_up,
  // power and mode outputs
  output logic port_enable,
  output logic core_clock_enable,
  output logic pads_tristate,
  output logic pulls_disable,
  output link_mode_t link_mode,
  output logic autoneg_start,
  output logic sleep_active,
  output logic regs_ready
);

  localparam int DIV_W = (TICK_LEN > 1) ? $clog2(TICK_LEN) : 1;

  logic init_reg, init_next;
  logic [DIV_W-1:0] div_reg, div_next;
  logic [3:0] rec_reg, rec_next;
  logic ready_reg, ready_next;
  logic tick;
  strap_t strap_reg, strap_next, pins_now;
  logic [15:0] ctrl_reg, ctrl_next, adv_reg, adv_next, cfg_reg, cfg_next;
  logic [3:0] swrst_reg, swrst_next;
  logic an_start_reg, an_start_next;
  sleep_state_t slp_reg, slp_next;
  logic [11:0] slp_cnt_reg, slp_cnt_next, slp_limit;
  mgmt_req_t req;
  logic [15:0] rd_data;
  logic mgmt_en, wr_ok, sleep_en;

  assign pins_now = '{an: indicator_strap_pins[0], speed: indicator_strap_pins[1],
                      duplex: indicator_strap_pins[2], sleep: sleep_pin, fiber: fiber_pin};

  // port is answered only after recovery, in managed mode, with power up
  assign mgmt_en = ready_reg & ~mgmt_port_disable_pin & ~hw_powerdown_pin; // see R07 see R17 see R20
  assign wr_ok = req.wr & mgmt_en & (swrst_reg == 4'h0); // see R01 see R02

  mgmt_serial_slave u_serial (
    .clk(clk),
    .rst_b(rst_b),
    .enable(mgmt_en),
    .phy_addr(phy_addr),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe),
    .req(req),
    .rd_data(rd_data)
  );

  // read mux; unmapped numbers read zero, restart bit reads zero
  always_comb begin
    case (req.addr)
      REG_BASIC_CONTROL: rd_data = ctrl_reg; // see R16
      REG_AUTONEG_ADVERTISE: rd_data = adv_reg;
      REG_VENDOR_CONFIGURATION: rd_data = cfg_reg;
      default: rd_data = 16'h0000; // see R21
    endcase
  end

  // ms divider and post-reset recovery window
  always_comb begin
    init_next = 1'b0;
    div_next = div_reg;
    rec_next = rec_reg;
    ready_next = ready_reg;
    tick = 1'b0;
    if (init_reg) begin
      div_next = '0; // divider restarts so recovery is a full ms
    end else if (div_reg == DIV_W'(TICK_LEN - 1)) begin
      div_next = '0;
      tick = 1'b1;
    end else begin
      div_next = div_reg + 1'b1;
    end
    if (tick && !ready_reg) begin
      rec_next = rec_reg + 4'h1;
      ready_next = (rec_next == 4'(RECOVERY_MS)); // see R17
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      init_reg <= 1'b1;
      div_reg <= '0;
      rec_reg <= 4'h0;
      ready_reg <= 1'b0;
    end else begin
      init_reg <= init_next;
      div_reg <= div_next;
      rec_reg <= rec_next;
      ready_reg <= ready_next;
    end
  end

  // register file, strap hold flops and software reset
  always_comb begin
    strap_next = strap_reg;
    ctrl_next = ctrl_reg;
    adv_next = adv_reg;
    cfg_next = cfg_reg;
    swrst_next = swrst_reg;
    an_start_next = 1'b0;
    if (init_reg) begin
      // first cycle after release: pins caught once, then held
      strap_next = pins_now; // see R23
      ctrl_next = strap_control(pins_now); // see R03 see R18
      adv_next = strap_advert(pins_now); // see R19
      cfg_next = strap_config(pins_now); // see R09
    end else if (swrst_reg != 4'h0) begin
      swrst_next = swrst_reg - 4'h1;
      if (swrst_reg == 4'h1) begin
        ctrl_next[CTRL_RESET] = 1'b0; // see R22 see R16
        an_start_next = 1'b1;
      end
    end else begin
      if (ready_next && !ready_reg) begin
        an_start_next = 1'b1; // see R04
      end
      if (wr_ok) begin
        case (req.addr)
          REG_BASIC_CONTROL: begin
            if (req.data[CTRL_RESET]) begin
              // held straps, never the live pins
              ctrl_next = strap_control(strap_reg); // see R14
              ctrl_next[CTRL_RESET] = 1'b1;
              adv_next = strap_advert(strap_reg); // see R15
              cfg_next = strap_config(strap_reg);
              swrst_next = SWRST_CYCLES;
            end else begin
              ctrl_next = req.data & CTRL_WMASK; // see R05 see R08
              an_start_next = req.data[CTRL_AN_RESTART] | (req.data[CTRL_AN_EN] & ~ctrl_reg[CTRL_AN_EN]);
            end
          end
          REG_AUTONEG_ADVERTISE: adv_next = (req.data & ADV_WMASK) | ADV_SELECTOR;
          REG_VENDOR_CONFIGURATION: cfg_next = req.data & CFG_WMASK; // see R10
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      strap_reg <= '0;
      ctrl_reg <= 16'h0000;
      adv_reg <= ADV_SELECTOR;
      cfg_reg <= CFG_RESET;
      swrst_reg <= 4'h0;
      an_start_reg <= 1'b0;
    end else begin
      strap_reg <= strap_next;
      ctrl_reg <= ctrl_next;
      adv_reg <= adv_next;
      cfg_reg <= cfg_next;
      swrst_reg <= swrst_next;
      an_start_reg <= an_start_next;
    end
  end

  // six selections; fiber wins over everything
  always_comb begin
    if (cfg_reg[CFG_FIBER]) begin
      link_mode = MODE_FX; // see R05
    end else if (ctrl_reg[CTRL_AN_EN]) begin
      link_mode = MODE_AUTONEG;
    end else if (ctrl_reg[CTRL_SPEED]) begin
      link_mode = ctrl_reg[CTRL_DUPLEX] ? MODE_TX_FULL : MODE_TX_HALF;
    end else begin
      link_mode = ctrl_reg[CTRL_DUPLEX] ? MODE_T_FULL : MODE_T_HALF;
    end
  end

  // sleep interval select and enable source
  always_comb begin
    case (cfg_reg[CFG_SLEEP_TIME +: 2])
      2'b00: slp_limit = SLEEP_MS_SHORT;
      2'b01: slp_limit = SLEEP_MS_MID;
      default: slp_limit = SLEEP_MS_LONG; // see R10
    endcase
  end
  assign sleep_en = mgmt_port_disable_pin ? sleep_pin : cfg_reg[CFG_SLEEP_EN]; // see R09

  // energy-detect sleep sequencer, counts ms ticks
  always_comb begin
    slp_next = slp_reg;
    slp_cnt_next = slp_cnt_reg;
    if (!sleep_en || cfg_reg[CFG_FIBER] || !ready_reg || hw_powerdown_pin) begin
      slp_next = SLP_AWAKE; // see R13
      slp_cnt_next = 12'h000;
    end else begin
      unique case (slp_reg)
        SLP_AWAKE: begin
          if (energy_detect || link_up) begin
            slp_cnt_next = 12'h000;
          end else if (tick) begin
            slp_cnt_next = slp_cnt_reg + 12'h001;
            if (slp_cnt_next == slp_limit) begin
              slp_next = SLP_ASLEEP; // see R10
              slp_cnt_next = 12'h000;
            end
          end
        end
        SLP_ASLEEP: begin
          if (energy_detect) begin
            slp_next = SLP_SEARCH; // see R12
          end
        end
        SLP_SEARCH: begin
          if (link_up) begin
            slp_next = SLP_AWAKE;
            slp_cnt_next = 12'h000;
          end else if (tick) begin
            slp_cnt_next = slp_cnt_reg + 12'h001;
            if (slp_cnt_next == slp_limit) begin
              slp_next = SLP_ASLEEP; // see R12
              slp_cnt_next = 12'h000;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      slp_reg <= SLP_AWAKE;
      slp_cnt_reg <= 12'h000;
    end else begin
      slp_reg <= slp_next;
      slp_cnt_reg <= slp_cnt_next;
    end
  end

  // power outputs; sleep leaves the management port alone
  assign sleep_active = (slp_reg == SLP_ASLEEP); // see R11
  assign port_enable = ready_reg & ~hw_powerdown_pin & ~ctrl_reg[CTRL_PWRDN] & ~sleep_active
                       & (swrst_reg == 4'h0); // see R08 see R06
  assign core_clock_enable = ~hw_powerdown_pin; // see R06
  assign pads_tristate = hw_powerdown_pin;
  assign pulls_disable = hw_powerdown_pin;
  assign autoneg_start = an_start_reg & (link_mode == MODE_AUTONEG) & port_enable; // see R04
  assign regs_ready = ready_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence swrst_begin;
    $rose(ctrl_reg[CTRL_RESET]);
  endsequence
  sequence swrst_done;
    ##[1:8] !ctrl_reg[CTRL_RESET];
  endsequence

  chk_pwrdn_no_mdio: assert property (hw_powerdown_pin |-> !mdio_oe) else $error("mdio driven in power-down"); // see R07
  chk_pwrdn_pads: assert property (hw_powerdown_pin |-> pads_tristate && pulls_disable && !port_enable
                                   && !core_clock_enable) else $error("power-down outputs wrong"); // see R06
  chk_swpdn_port: assert property (ctrl_reg[CTRL_PWRDN] |-> !port_enable) else $error("port on in soft power-down"); // see R08
  chk_strap_write_block: assert property (mgmt_port_disable_pin && !init_reg
                                          |=> $stable(adv_reg) && $stable(cfg_reg))
    else $error("write taken in strap mode"); // see R02
  chk_swrst_self_clear: assert property (swrst_begin |-> swrst_done) else $error("reset bit stuck"); // see R22
  chk_swrst_restore: assert property (swrst_begin |-> adv_reg == strap_advert(strap_reg))
    else $error("advertisement not restored"); // see R15
  chk_fiber_no_sleep: assert property (cfg_reg[CFG_FIBER] |=> !sleep_active) else $error("sleep in fiber mode"); // see R13
  chk_recovery_quiet: assert property (!ready_reg |-> !mdio_oe && !req.wr && !an_start_reg)
    else $error("access during recovery"); // see R17
  chk_wake_on_energy: assert property (sleep_active && energy_detect && sleep_en && !hw_powerdown_pin
                                       && !cfg_reg[CFG_FIBER] |=> slp_reg == SLP_SEARCH)
    else $error("no wake on energy"); // see R12
  chk_strap_an_load: assert property (init_reg |=> ctrl_reg[CTRL_AN_EN] == $past(indicator_strap_pins[0])
                                      && strap_reg.an == $past(indicator_strap_pins[0])) else $error("strap not loaded"); // see R03
  chk_strap_an_speed: assert property (init_reg && indicator_strap_pins[0] |=> ctrl_reg[CTRL_SPEED]
                                       && adv_reg[ADV_100_HALF]) else $error("autoneg strap decode wrong"); // see R19

endmodule : phy_config_reset_power

`default_nettype wire

/* File: phy_config_reset_power_tb.sv */
// testbench: straps, register access, resets and power modes
// assumes the station model owns mdc and mdio; all inputs change 5 ns after clk rises
`default_nettype none

module phy_config_reset_power_tb
  import phy_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TL = 4; // short ms tick keeps sleep waits brief
  localparam logic [4:0] PA = 5'h05;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] straps = 3'h0;
  logic sleep_pin = 1'b0;
  logic fiber_pin = 1'b0;
  logic dis = 1'b0;
  logic pd = 1'b0;
  logic energy = 1'b1;
  logic link_up = 1'b0;
  logic mdc, mdio_in, mdio_out, mdio_oe, port_enable, core_clock_enable, pads_tristate, pulls_disable;
  logic autoneg_start, sleep_active, regs_ready;
  link_mode_t link_mode;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;

  // 20 MHz clock
  always #25 clk = ~clk;

  phy_config_reset_power #(.TICK_LEN(TL)) phy_config_reset_power_i (.clk, .rst_b, .indicator_strap_pins(straps),
    .sleep_pin, .fiber_pin, .mgmt_port_disable_pin(dis), .hw_powerdown_pin(pd), .phy_addr(PA), .mdc, .mdio_in,
    .mdio_out, .mdio_oe, .energy_detect(energy), .link_up, .port_enable, .core_clock_enable, .pads_tristate,
    .pulls_disable, .link_mode, .autoneg_start, .sleep_active, .regs_ready);
  mgmt_station mgmt_station_i (.clk, .mdc, .mdio_in, .mdio_out, .mdio_oe);

  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #5;
  endtask : tick

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    mgmt_station_i.frame(1'b1, PA, ra, d, x);
  endtask : wr

  // a silent device leaves the pulled-up line, so a refused read gives all ones
  task automatic rd_chk(input string n, input logic [4:0] ra, input logic [15:0] e);
    logic [15:0] x;
    mgmt_station_i.frame(1'b0, PA, ra, 16'h0000, x);
    chk(n, e, x);
  endtask : rd_chk

  task automatic wait_ready(output int n);
    n = 0;
    while (regs_ready !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
  endtask : wait_ready

  task automatic t_strap(input logic [2:0] s, input logic sl, input logic fb, input logic [15:0] c, a, f,
                         input link_mode_t m);
    int n;
    rst_b = 1'b0;
    straps = s;
    sleep_pin = sl;
    fiber_pin = fb;
    tick(5);
    rst_b = 1'b1;
    wait_ready(n);
    chk("ready_delay", 16'(TL + 1), n[15:0]);
    chk("an_start", {15'h0, m == MODE_AUTONEG}, {15'h0, autoneg_start});
    tick(1);
    chk("an_pulse", 16'h0, {15'h0, autoneg_start});
    chk("mode", {13'h0, m}, {13'h0, link_mode});
    straps = ~s;
    fiber_pin = ~fb;
    rd_chk("ctrl", REG_BASIC_CONTROL, c);
    rd_chk("adv", REG_AUTONEG_ADVERTISE, a);
    rd_chk("cfg", REG_VENDOR_CONFIGURATION, f);
  endtask : t_strap

  task automatic t_mode(input logic [15:0] c, input link_mode_t m);
    wr(REG_BASIC_CONTROL, c);
    chk("mode_wr", {13'h0, m}, {13'h0, link_mode});
    rd_chk("ctrl_wr", REG_BASIC_CONTROL, c);
  endtask : t_mode

  task automatic t_swpd;
    wr(REG_BASIC_CONTROL, 16'h0800);
    chk("port_pd", 16'h0, {15'h0, port_enable});
    rd_chk("ctrl_pd", REG_BASIC_CONTROL, 16'h0800);
  endtask : t_swpd

  // pins now differ from the held straps, so a resample would show
  task automatic t_swreset;
    wr(REG_AUTONEG_ADVERTISE, 16'h0000);
    wr(REG_BASIC_CONTROL, 16'h8000);
    rd_chk("ctrl_sr", REG_BASIC_CONTROL, 16'h3100);
    rd_chk("adv_sr", REG_AUTONEG_ADVERTISE, 16'h0181);
    chk("port_sr", 16'h1, {15'h0, port_enable});
  endtask : t_swreset

  task automatic t_strapmode;
    dis = 1'b1;
    wr(REG_BASIC_CONTROL, 16'h0000);
    rd_chk("rd_off", REG_BASIC_CONTROL, 16'hffff);
    dis = 1'b0;
    rd_chk("ctrl_kept", REG_BASIC_CONTROL, 16'h3100);
  endtask : t_strapmode

  task automatic t_hwpd;
    int n;
    pd = 1'b1;
    tick(1);
    chk("pd_pins", 16'hc, {12'h0, pads_tristate, pulls_disable, core_clock_enable, port_enable});
    rd_chk("rd_pd", REG_BASIC_CONTROL, 16'hffff);
    pd = 1'b0;
    wait_ready(n);
    rd_chk("ctrl_up", REG_BASIC_CONTROL, 16'h3100);
  endtask : t_hwpd

  task automatic t_sleep;
    wr(REG_VENDOR_CONFIGURATION, 16'h0040);
    energy = 1'b0;
    tick(1040 * TL - 20);
    chk("sleep_early", 16'h0, {15'h0, sleep_active});
    tick(40);
    chk("sleep_late", 16'h1, {15'h0, sleep_active});
    rd_chk("cfg_asleep", REG_VENDOR_CONFIGURATION, 16'h0040);
    energy = 1'b1;
    tick(2);
    chk("wake", 16'h0, {15'h0, sleep_active});
    energy = 1'b0;
    tick(1040 * TL + 20);
    chk("resleep", 16'h1, {15'h0, sleep_active});
    wr(REG_VENDOR_CONFIGURATION, 16'h0048);
    energy = 1'b1;
    tick(2);
    energy = 1'b0;
    tick(2040 * TL - 20);
    chk("search_mid", 16'h0, {15'h0, sleep_active});
    tick(40);
    chk("resleep_mid", 16'h1, {15'h0, sleep_active});
    wr(REG_VENDOR_CONFIGURATION, 16'h0041);
    chk("fiber_awake", 16'h0, {15'h0, sleep_active});
  endtask : t_sleep

  // main sequence
  initial begin
    t_strap(3'b110, 1'b1, 1'b0, 16'h2100, 16'h01e1, 16'h0050, MODE_TX_FULL);
    t_strap(3'b010, 1'b0, 1'b1, 16'h2000, 16'h01e1, 16'h0011, MODE_FX);
    t_strap(3'b011, 1'b0, 1'b0, 16'h3000, 16'h00a1, 16'h0010, MODE_AUTONEG);
    t_strap(3'b101, 1'b0, 1'b0, 16'h3100, 16'h0181, 16'h0010, MODE_AUTONEG);
    t_mode(16'h2000, MODE_TX_HALF);
    t_mode(16'h0100, MODE_T_FULL);
    t_mode(16'h0000, MODE_T_HALF);
    t_mode(16'h3100, MODE_AUTONEG);
    t_swpd;
    t_swreset;
    t_strapmode;
    t_hwpd;
    t_sleep;
    close_out();
  end

  // hang guard: about 1.7 times the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      close_out();
    end
  end
endmodule : phy_config_reset_power_tb

`default_nettype wire
